// [hw/channel_gain_mute_config.sv]
// Function
// - Each quarter-step bit adds a quarter dB to its channel gain.
// - Quarter-step changes follow the same zero-crossing policy and time-out.
// - Any setting accepted; effective gain clamped between +22 dB and -96 dB.
// - Channel silence bits 0-7 mute channels 1-8 while set, reset clear.
// - Pin enable bit 5, default set, lets the external pin force mute.
// - Pin level bit 4 selects active-high when set, active-low when clear.
// - Pairing set: both channels follow the lower channel; upper settings ignored.
// - Pairing clear, the reset value: channels follow their own settings.
// - Pair bits 3..0 couple channels 7/8, 5/6, 3/4, 1/2; odd is source.
// - Time-out field bits 4:2, reset 011, selects 5 to 50 ms.
// - Policy 00 applies at once; 01 waits, newer change discards pending.
// - Policy 10 applies pending on newer change, then waits; 11 reserved.
module channel_gain_mute_config #(
   parameter logic [7:0][20:0] TIMEOUT_CYC = vol_pkg::TIMEOUT_CYC_DEF
) (
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        ce_i,
   // Register port from the serial control port
   input  wire logic        wr_en_i,
   input  wire logic        rd_en_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   // Half-dB volume codes, channel c at bits 8c+7:8c
   input  wire logic [63:0] vol_code_i,
   // Pins
   input  wire logic        ext_silence_pin_i,
   input  wire logic [7:0]  zero_cross_i,
   // Effective channel state, channel c gain at bits 10c+9:10c
   output logic      [79:0] gain_o,
   output logic      [7:0]  mute_o,
   output logic      [7:0]  pending_o
);
   logic [7:0] quarter_r;
   logic [7:0] silence_r;
   logic [7:0] cfg1_r;
   logic [7:0] cfg2_r;
   logic       pin_s1_r;
   logic       pin_s2_r;
   logic [7:0] zc_s1_r;
   logic [7:0] zc_s2_r;
   logic [7:0] mute_nxt;
   logic [7:0] rdata_nxt;

   // Register decode
   wire wr_w      = wr_en_i && ce_i;
   wire sel_q_w   = addr_i == vol_pkg::QUARTER_OFS;
   wire sel_s_w   = addr_i == vol_pkg::SILENCE_OFS;
   wire sel_c1_w  = addr_i == vol_pkg::CFG1_OFS;
   wire sel_c2_w  = addr_i == vol_pkg::CFG2_OFS;

   // Readback mux; unmapped addresses read zero
   assign rdata_nxt = sel_q_w  ? quarter_r :
                      sel_s_w  ? silence_r :
                      sel_c1_w ? cfg1_r    :
                      sel_c2_w ? cfg2_r    : 8'h00;

   // Configuration fields
   wire       pin_en_w    = cfg1_r[vol_pkg::PIN_EN_BIT];
   wire       pin_level_w = cfg1_r[vol_pkg::PIN_LEVEL_BIT];
   wire [3:0] pair_w      = cfg1_r[vol_pkg::PAIR_LSB +: 4];
   wire [2:0] to_sel_w    = cfg2_r[vol_pkg::TO_LSB +: 3];
   wire [1:0] policy_w    = cfg2_r[vol_pkg::POLICY_LSB +: 2];
   wire [20:0] load_w     = TIMEOUT_CYC[to_sel_w];

   wire pin_force_w = pin_en_w && (pin_level_w ? pin_s2_r : !pin_s2_r);

   // Register writes; reserved bits never stored
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         quarter_r <= vol_pkg::QUARTER_RST;
         silence_r <= vol_pkg::SILENCE_RST;
         cfg1_r    <= vol_pkg::CFG1_RST;
         cfg2_r    <= vol_pkg::CFG2_RST;
      end else if (wr_w) begin
         if (sel_q_w) quarter_r <= wdata_i;
         if (sel_s_w) silence_r <= wdata_i;
         if (sel_c1_w) cfg1_r <= wdata_i & vol_pkg::CFG1_MASK;
         if (sel_c2_w) cfg2_r <= wdata_i & vol_pkg::CFG2_MASK;
      end
   end

   // Read data register, holds between reads
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i && rd_en_i) begin
         rdata_o <= rdata_nxt;
      end
   end

   // Two-stage synchronisers for the asynchronous pins
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         zc_s1_r  <= 8'h00;
         zc_s2_r  <= 8'h00;
      end else if (ce_i) begin
         pin_s1_r <= ext_silence_pin_i;
         pin_s2_r <= pin_s1_r;
         zc_s1_r  <= zero_cross_i;
         zc_s2_r  <= zc_s1_r;
      end
   end

   // Mute output register; mute acts at once, not on a zero-crossing
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mute_o <= 8'h00;
      end else if (ce_i) begin
         mute_o <= mute_nxt;
      end
   end

   // Per-channel source selection, gain math and update logic
   for (genvar c = 0; c < 8; c++) begin : g_ch
      localparam int SRC = c - (c % 2);
      logic signed [10:0] half_w;
      logic signed [10:0] raw_w;
      logic signed [10:0] clamp_w;

      // odd channel slaved to its partner
      // pair bit clear keeps own settings
      // bit c/2 pairs channels SRC and SRC+1
      wire use_src_w = (c % 2 == 1) && pair_w[c / 2];
      wire [7:0] code_w = use_src_w ? vol_code_i[8*SRC +: 8] : vol_code_i[8*c +: 8];
      wire qtr_w        = use_src_w ? quarter_r[SRC] : quarter_r[c];
      wire sil_w        = use_src_w ? silence_r[SRC] : silence_r[c];

      // two quarter steps per code, plus the quarter bit
      assign half_w = $signed({3'b000, code_w}) - vol_pkg::ZERO_DB_CODE;
      assign raw_w  = $signed({half_w[9:0], 1'b0}) + $signed({10'h000, qtr_w});
      assign clamp_w = (raw_w > vol_pkg::GAIN_MAX_Q) ? vol_pkg::GAIN_MAX_Q :
                       (raw_w < vol_pkg::GAIN_MIN_Q) ? vol_pkg::GAIN_MIN_Q : raw_w;

      // silence bit or pin holds the channel muted
      assign mute_nxt[c] = sil_w || pin_force_w;

      // quarter changes share the zero-crossing path
      zc_channel u_zc (
         .clk_i     (clk_i),
         .resetn_i  (resetn_i),
         .ce_i      (ce_i),
         .target_i  (clamp_w[9:0]),
         .policy_i  (policy_w),
         .load_i    (load_w),
         .zc_i      (zc_s2_r[c]),
         .applied_o (gain_o[10*c +: 10]),
         .pending_o (pending_o[c])
      );
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   silence_mute_a: assert property (
      ce_i && silence_r[0] |=> mute_o[0])
      else $error("silence bit did not mute channel 1");
   pin_force_a: assert property (
      ce_i && pin_en_w && !pin_level_w && !pin_s2_r |=> mute_o == 8'hFF)
      else $error("active-low pin did not mute all channels");
   pin_ignored_a: assert property (
      ce_i && !pin_en_w && silence_r == 8'h00 && !wr_w |=> mute_o == 8'h00)
      else $error("disabled pin still muted");
   pin_high_a: assert property (
      ce_i && pin_en_w && pin_level_w && pin_s2_r |=> mute_o == 8'hFF)
      else $error("active-high pin did not mute");
   pair_follow_a: assert property (
      pair_w[0] |-> g_ch[1].clamp_w == g_ch[0].clamp_w && mute_nxt[1] == mute_nxt[0])
      else $error("paired channel 2 not following channel 1");
   quarter_step_a: assert property (
      !pair_w[0] && vol_code_i[7:0] == 8'hD2 && quarter_r[0] |-> g_ch[0].clamp_w == 11'sd1)
      else $error("quarter bit did not add one quarter dB");
   gain_clamp_a: assert property (
      vol_code_i[7:0] == 8'hFF |-> g_ch[0].clamp_w == vol_pkg::GAIN_MAX_Q)
      else $error("top code not limited to maximum gain");
   gain_floor_a: assert property (
      !pair_w[0] && vol_code_i[15:8] == 8'h00 |-> g_ch[1].clamp_w == vol_pkg::GAIN_MIN_Q)
      else $error("bottom code not limited to minimum gain");
   reserved_zero_a: assert property (
      cfg1_r[7:6] == 2'h0 && cfg2_r[7:5] == 3'h0)
      else $error("reserved bits stored");
   timeout_sel_a: assert property (
      to_sel_w == 3'h3 |-> load_w == TIMEOUT_CYC[3])
      else $error("time-out select wrong");
   pin_mute_c: cover property (ce_i && pin_force_w ##1 mute_o == 8'hFF);
   pair_c: cover property (ce_i && pair_w == 4'hF);
   cfg_write_c: cover property (wr_w && sel_c2_w);
endmodule

// [hw/zc_channel.sv]
module zc_channel (
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        ce_i,
   // Requested gain and policy
   input  wire logic [9:0]  target_i,
   input  wire logic [1:0]  policy_i,
   input  wire logic [20:0] load_i,
   input  wire logic        zc_i,
   // Applied gain
   output logic      [9:0]  applied_o,
   output logic             pending_o
);
   logic [9:0]  last_r;
   logic [9:0]  pend_val_r;
   logic [20:0] timer_r;
   logic [9:0]  applied_nxt;
   logic [9:0]  pend_val_nxt;
   logic [20:0] timer_nxt;
   logic        pending_nxt;

   // Decode of change, policy and expiry
   wire changed_w   = target_i != last_r;
   wire immediate_w = (policy_i == vol_pkg::POLICY_NOW) || (policy_i == 2'h3);
   wire flush_w     = (policy_i == vol_pkg::POLICY_FLUSH) && pending_o;
   wire expire_w    = pending_o && (zc_i || timer_r == 21'h000001);

   // flush older change on a newer one
   assign applied_nxt  = (changed_w && immediate_w) ? target_i :
                         (changed_w && flush_w)     ? pend_val_r :
                         (!changed_w && expire_w)   ? pend_val_r : applied_o;
   assign pend_val_nxt = (changed_w && !immediate_w) ? target_i : pend_val_r;
   assign pending_nxt  = changed_w ? !immediate_w : (expire_w ? 1'b0 : pending_o);
   assign timer_nxt    = changed_w ? load_i :
                         (pending_o ? timer_r - 21'h000001 : timer_r);

   // State update, frozen while ce_i is low
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         last_r     <= 10'h000;
         pend_val_r <= 10'h000;
         timer_r    <= 21'h000000;
         applied_o  <= 10'h000;
         pending_o  <= 1'b0;
      end else if (ce_i) begin
         last_r     <= target_i;
         pend_val_r <= pend_val_nxt;
         timer_r    <= timer_nxt;
         applied_o  <= applied_nxt;
         pending_o  <= pending_nxt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   immediate_apply_a: assert property (
      ce_i && changed_w && policy_i == vol_pkg::POLICY_NOW |=> applied_o == $past(target_i))
      else $error("policy 00 change not applied at once");
   discard_hold_a: assert property (
      ce_i && changed_w && policy_i == vol_pkg::POLICY_DISCARD
      |=> pending_o && applied_o == $past(applied_o))
      else $error("policy 01 change did not wait");
   flush_old_a: assert property (
      ce_i && changed_w && policy_i == vol_pkg::POLICY_FLUSH && pending_o
      |=> applied_o == $past(pend_val_r) && pend_val_r == $past(target_i))
      else $error("policy 10 did not flush pending change");
   zc_apply_a: assert property (
      ce_i && pending_o && !changed_w && zc_i |=> !pending_o && applied_o == $past(pend_val_r))
      else $error("zero-crossing did not apply pending gain");
   timer_restart_a: assert property (
      ce_i && changed_w && !immediate_w |=> timer_r == $past(load_i))
      else $error("time-out not restarted on change");
   zc_wait_c: cover property (ce_i && pending_o && zc_i && !changed_w);
   flush_c: cover property (ce_i && changed_w && flush_w);
endmodule

// [shared/vol_pkg.sv]
package vol_pkg;
   // Core clock and derived millisecond count
   localparam int unsigned CLK_HZ     = 40_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // Register offsets
   localparam logic [7:0] QUARTER_OFS = 8'h09;
   localparam logic [7:0] SILENCE_OFS = 8'h0A;
   localparam logic [7:0] CFG1_OFS    = 8'h0B;
   localparam logic [7:0] CFG2_OFS    = 8'h0C;

   // Reset values
   localparam logic [7:0] QUARTER_RST = 8'h00;
   localparam logic [7:0] SILENCE_RST = 8'h00;
   localparam logic [7:0] CFG1_RST    = 8'h20;
   localparam logic [7:0] CFG2_RST    = 8'h0D;

   // Writable bits; reserved bits are masked off
   localparam logic [7:0] CFG1_MASK = 8'h3F;
   localparam logic [7:0] CFG2_MASK = 8'h1F;

   // Field positions
   localparam int PIN_EN_BIT    = 5;
   localparam int PIN_LEVEL_BIT = 4;
   localparam int PAIR_LSB      = 0;
   localparam int TO_LSB        = 2;
   localparam int POLICY_LSB    = 0;

   // Zero-crossing policies
   localparam logic [1:0] POLICY_NOW     = 2'h0;
   localparam logic [1:0] POLICY_DISCARD = 2'h1;
   localparam logic [1:0] POLICY_FLUSH   = 2'h2;

   // Gain arithmetic, in quarter dB
   localparam logic signed [10:0] ZERO_DB_CODE = 11'sd210;
   localparam logic signed [10:0] GAIN_MAX_Q   = 11'sd88;
   localparam logic signed [10:0] GAIN_MIN_Q   = -11'sd384;

   // Time-out periods in ms and their cycle counts
   localparam int unsigned TO0_MS = 5;
   localparam int unsigned TO1_MS = 10;
   localparam int unsigned TO2_MS = 15;
   localparam int unsigned TO3_MS = 18;
   localparam int unsigned TO4_MS = 20;
   localparam int unsigned TO5_MS = 30;
   localparam int unsigned TO6_MS = 40;
   localparam int unsigned TO7_MS = 50;
   localparam logic [7:0][20:0] TIMEOUT_CYC_DEF = {
      21'(TO7_MS * CYC_PER_MS), 21'(TO6_MS * CYC_PER_MS),
      21'(TO5_MS * CYC_PER_MS), 21'(TO4_MS * CYC_PER_MS),
      21'(TO3_MS * CYC_PER_MS), 21'(TO2_MS * CYC_PER_MS),
      21'(TO1_MS * CYC_PER_MS), 21'(TO0_MS * CYC_PER_MS)};
endpackage

// [sim/ctrl_model.sv]
// Controller side of the register port; drives just after the falling edge
module ctrl_model (
   // Clock
   input  wire logic       clk_i,
   // Register port requests
   output logic            wr_en_o,
   output logic            rd_en_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle port at time zero
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end

   // One-cycle write; released lines show inverted values, never stale ones
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_i);
      wr_en_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_en_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask

   // One-cycle read; data is settled on return
   task automatic rd(input logic [7:0] a);
      @(negedge clk_i);
      rd_en_o = 1'b1;
      addr_o = a;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      addr_o = ~a;
   endtask
endmodule

// [sim/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Short time-outs keep the run brief
   localparam logic [7:0][20:0] TO_CYC = {21'd200, 21'd160, 21'd120, 21'd80,
                                          21'd72, 21'd60, 21'd40, 21'd20};
   typedef struct {int k; int c; logic [9:0] e;} note_s;
   logic        clk = 1'b0, resetn = 1'b0, pin = 1'b1, frc = 1'b0, ce = 1'b1, wr_en, rd_en;
   logic [7:0]  addr, wdata, rdata, mute, pend, zc = 8'h00, qt, sil, pr, rnd = 8'h4A;
   logic [63:0] vol = {8{8'hD2}};
   logic [79:0] gain;
   logic [9:0]  old_g, new_g, g0;
   note_s       q[$], nt;
   int          n_mismatch = 0, checks_done = 0, cyc = 0;
   event        look_ev;

   // Clock at 40 MHz
   always #12.5 clk = ~clk;

   ctrl_model m (.clk_i(clk), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
                 .wdata_o(wdata));
   channel_gain_mute_config #(.TIMEOUT_CYC(TO_CYC)) u_dut (
      .clk_i(clk), .resetn_i(resetn), .ce_i(ce), .wr_en_i(wr_en), .rd_en_i(rd_en),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .vol_code_i(vol),
      .ext_silence_pin_i(pin), .zero_cross_i(zc), .gain_o(gain), .mute_o(mute),
      .pending_o(pend));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Half-dB code plus quarter step, limited to the analog range
   function automatic logic [9:0] gexp(input logic [7:0] code, input logic qb);
      int v;
      v = 2 * (int'(code) - 210) + int'(qb);
      if (v > 88) v = 88;
      if (v < -384) v = -384;
      return 10'(v);
   endfunction

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic note(input int k, c, input logic [9:0] e);
      q.push_back('{k, c, e});
      ->look_ev;
   endtask

   task automatic cmp8(input logic [7:0] got, ev);
      checks_done++;
      if (got !== ev) begin
         n_mismatch++;
         $display("MISMATCH t=%0t flags or data got %h exp %h", $time, got, ev);
      end
   endtask

   task automatic cmp10(input logic [9:0] got, ev);
      checks_done++;
      if (got !== ev) begin
         n_mismatch++;
         $display("MISMATCH t=%0t gain got %h exp %h", $time, got, ev);
      end
   endtask

   task automatic cmp1(input logic got, ev);
      checks_done++;
      if (got !== ev) begin
         n_mismatch++;
         $display("MISMATCH t=%0t pending got %b exp %b", $time, got, ev);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, e);
      m.rd(a);
      note(0, 0, {2'b00, e});
   endtask

   // Expected gains and mutes of all channels, pair sources resolved
   task automatic chk_all();
      int s;
      logic [7:0] me;
      me = 8'h00;
      for (int c = 0; c < 8; c++) begin
         s = (c % 2 == 1 && pr[c / 2]) ? c - 1 : c;
         note(1, c, gexp(vol[8 * s +: 8], qt[s]));
         me[c] = sil[s] | frc;
      end
      note(2, 0, {2'b00, me});
   endtask

   // New volume for channel 1, keeping the gains before and after
   task automatic step(input logic [7:0] v);
      old_g = gexp(vol[7:0], qt[0]);
      vol[7:0] = v;
      new_g = gexp(v, qt[0]);
   endtask

   task automatic conclude();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Oldest note is compared against the output it names
   always begin
      @(look_ev);
      while (q.size() > 0) begin
         nt = q.pop_front();
         case (nt.k)
            0: cmp8(rdata, nt.e[7:0]);
            1: cmp10(gain[10 * nt.c +: 10], nt.e);
            2: cmp8(mute, nt.e[7:0]);
            default: cmp1(pend[nt.c], nt.e[0]);
         endcase
      end
   end

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      wt(10);
      resetn = 1'b1;
      // Reset values, unmapped place and reserved bits
      rdchk(8'h09, 8'h00);
      rdchk(8'h0A, 8'h00);
      rdchk(8'h0B, 8'h20);
      rdchk(8'h0C, 8'h0D);
      m.wr(8'h20, 8'h55);
      rdchk(8'h20, 8'h00);
      m.wr(8'h0B, 8'hFF);
      rdchk(8'h0B, 8'h3F);
      m.wr(8'h0C, 8'hFC);
      rdchk(8'h0C, 8'h1C);
      // Immediate policy with random codes, pairing, silence and pin
      for (int i = 0; i < 6; i++) begin
         for (int b = 0; b < 8; b++) begin
            rnd = lfsr(rnd);
            vol[8 * b +: 8] = rnd;
         end
         if (i == 0) vol[15:0] = 16'h00FF;
         qt = lfsr(rnd);
         sil = lfsr(qt);
         pr = {4'h0, sil[5:2] ^ qt[3:0]};
         rnd = lfsr(sil);
         pin = rnd[0];
         // Reserved policy code must behave as the immediate one
         if (i == 3) m.wr(8'h0C, 8'h1F);
         m.wr(8'h09, qt);
         m.wr(8'h0A, sil);
         m.wr(8'h0B, {2'b00, rnd[2:1], pr[3:0]});
         frc = rnd[2] && (pin == rnd[1]);
         wt(6);
         chk_all();
      end
      // Writes while the clock enable is low are ignored, state holds
      ce = 1'b0;
      m.wr(8'h0A, ~sil);
      ce = 1'b1;
      rdchk(8'h0A, sil);
      chk_all();
      step(8'hD2);
      wt(4);
      // Every time-out code with no zero-crossing
      for (int t = 0; t < 8; t++) begin
         m.wr(8'h0C, {3'b000, 3'(t), 2'b01});
         step(vol[7:0] ^ 8'h01);
         wt(int'(TO_CYC[t]) - 4);
         note(1, 0, old_g);
         note(3, 0, 10'h001);
         wt(8);
         note(1, 0, new_g);
         note(3, 0, 10'h000);
      end
      // Quarter step held until a zero-crossing
      m.wr(8'h0C, 8'h1D);
      old_g = gexp(vol[7:0], qt[0]);
      qt[0] = ~qt[0];
      new_g = gexp(vol[7:0], qt[0]);
      m.wr(8'h09, qt);
      wt(10);
      note(1, 0, old_g);
      zc = 8'h01;
      wt(5);
      note(1, 0, new_g);
      zc = 8'h00;
      // Synchronised crossing must drain, or it would apply the next change
      wt(3);
      // Newer change discards the pending one and restarts the timer
      step(vol[7:0] ^ 8'h01);
      g0 = old_g;
      wt(20);
      step(vol[7:0] ^ 8'h02);
      wt(185);
      note(1, 0, g0);
      wt(25);
      note(1, 0, new_g);
      // Newer change applies the pending one at once, then waits
      m.wr(8'h0C, 8'h1E);
      step(vol[7:0] ^ 8'h01);
      g0 = new_g;
      wt(20);
      step(vol[7:0] ^ 8'h02);
      wt(6);
      note(1, 0, g0);
      note(3, 0, 10'h001);
      wt(210);
      note(1, 0, new_g);
      wt(2);
      conclude();
   end
endmodule
